// ===== bench/tb_adc_gain_adjust.sv
// Self-checking bench for the converter gain adjustment block
`timescale 1ns/1ps
`default_nettype none
module tb_adc_gain_adjust;
    import gain_pkg::*;
    logic clk_sys;
    logic rst_b;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    sample_t raw_in;
    sample_t result_out;
    logic [GAIN_NUM_W-1:0] gain_setting;
    logic [DATA_W-1:0] rd_val;
    int errors;
    int n_compared;

    gain_adjust uut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_in(raw_in),
        .result_out(result_out), .gain_setting(gain_setting));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////
    task automatic results;
        if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Reference scaling: drop fraction, clamp at full scale
    function automatic logic [11:0] scaled(input int d, input int g);
        int p;
        p = (d * g) >>> 12;
        return (p > 4095) ? 12'hFFF : 12'(p);
    endfunction

    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check(16'(gain_setting), 16'h1000, "reset gain");
        rd_reg(8'h04, rd_val);
        check(16'(rd_val), 16'h00FC, "reset high");
        @(posedge clk_sys);
        #1 check(16'(reg_rdata), 16'h0000, "rdata idle");
        rd_reg(8'h07, rd_val);
        check(16'(rd_val), 16'h0000, "reset low");
        rd_reg(8'h08, rd_val);
        check(16'(rd_val), 16'h0001, "reset extra");
    endtask

    // Reset in mid-run must bring every register back to its reset value
    task automatic t_rerun_reset;
        wr_reg(8'h04, 8'h11);
        wr_reg(8'h08, 8'h00);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 check(16'(result_out), 16'h0000, "result in reset");
        @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
    endtask

    task automatic t_regs;
        wr_reg(8'h04, 8'h5A);
        rd_reg(8'h04, rd_val);
        check(16'(rd_val), 16'h005A, "high rw");
        wr_reg(8'h07, 8'h50);
        rd_reg(8'h07, rd_val);
        check(16'(rd_val), 16'h0050, "low nibble");
        wr_reg(8'h08, 8'hFE);
        rd_reg(8'h08, rd_val);
        check(16'(rd_val), 16'h0000, "extra bit");
        check(16'(gain_setting), 16'h05A5, "gain word");
        wr_reg(8'h05, 8'h33);
        rd_reg(8'h05, rd_val);
        check(16'(rd_val), 16'h0000, "unmapped read");
        rd_reg(8'h04, rd_val);
        check(16'(rd_val), 16'h005A, "unmapped write");
    endtask

    // Two samples back to back, each answered one cycle later
    task automatic t_scale(input logic [7:0] h, input logic [7:0] l, input logic e);
        int g;
        g = {h, l[7:4]} + (e ? 64 : 0);
        wr_reg(8'h04, h);
        wr_reg(8'h07, l);
        wr_reg(8'h08, {7'h00, e});
        #1 check(16'(gain_setting), 16'(g), "gain value");
        @(posedge clk_sys);
        raw_in <= {1'b1, 12'hFFF};
        @(posedge clk_sys);
        raw_in <= {1'b1, 12'h801};
        #1 check(16'(result_out), 16'({1'b1, scaled(4095, g)}), "full scale");
        @(posedge clk_sys);
        raw_in <= '0;
        #1 check(16'(result_out), 16'({1'b1, scaled(2049, g)}), "mid scale");
        @(posedge clk_sys);
        #1 check(16'(result_out), 16'({1'b0, scaled(2049, g)}), "single pulse, data held");
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        n_compared = 0;
        rst_b = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        raw_in = '0;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_regs();
        t_scale(8'hFF, 8'hF0, 1'b1);
        t_scale(8'h00, 8'h00, 1'b0);
        t_scale(8'h12, 8'h30, 1'b0);
        t_scale(8'hFC, 8'h00, 1'b1);
        t_rerun_reset();
        results();
    end

    initial begin
        #200000;
        errors++;
        results();
    end
endmodule
`default_nettype wire

// ===== common/gain_pkg.sv
// Shared constants, types and arithmetic for the converter gain adjustment block
package gain_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int RESULT_W = 12;
    localparam int GAIN_W = 12;
    localparam int GAIN_NUM_W = 13;
    localparam int PROD_W = RESULT_W + GAIN_NUM_W;
    localparam int FRAC_BITS = 12;
    localparam int HIGH_FIELD_W = 8;
    localparam int LOW_FIELD_W = 4;
    localparam int LOW_FIELD_LSB = 4;
    localparam int EXTRA_BIT = 0;
    localparam int EXTRA_SHIFT = 6;

    localparam logic [ADDR_W-1:0] OFF_GAIN_HIGH = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_GAIN_LOW = 8'h07;
    localparam logic [ADDR_W-1:0] OFF_GAIN_EXTRA = 8'h08;

    localparam logic [DATA_W-1:0] RST_GAIN_HIGH = 8'hFC;
    localparam logic [DATA_W-1:0] RST_GAIN_LOW = 8'h00;
    localparam logic [DATA_W-1:0] RST_GAIN_EXTRA = 8'h01;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

    localparam logic [GAIN_NUM_W-1:0] GAIN_MAX = 13'h103F;
    localparam logic [RESULT_W-1:0] RESULT_MAX = 12'hFFF;

    typedef struct packed {
        logic valid;
        logic [RESULT_W-1:0] data;
    } sample_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    // Gain numerator in units of 1/4096; extra bit adds 64/4096
    function automatic logic [GAIN_NUM_W-1:0] gain_value(
        input logic [HIGH_FIELD_W-1:0] high_field,
        input logic [LOW_FIELD_W-1:0] low_field,
        input logic extra_flag
    );
        logic [GAIN_NUM_W-1:0] word;
        logic [GAIN_NUM_W-1:0] extra;
        word = {1'b0, high_field, low_field};
        extra = GAIN_NUM_W'(extra_flag) << EXTRA_SHIFT;
        return GAIN_NUM_W'(word + extra);
    endfunction

    // Scale a raw result, drop fraction bits, clamp to the result width
    function automatic logic [RESULT_W-1:0] scale_sample(
        input logic [RESULT_W-1:0] raw,
        input logic [GAIN_NUM_W-1:0] gain
    );
        logic [PROD_W-1:0] prod;
        logic [PROD_W-FRAC_BITS-1:0] whole;
        prod = PROD_W'(raw) * PROD_W'(gain);
        whole = prod[PROD_W-1:FRAC_BITS];
        if (whole > (PROD_W-FRAC_BITS)'(RESULT_MAX)) begin
            return RESULT_MAX;
        end
        return whole[RESULT_W-1:0];
    endfunction

endpackage

// ===== core/gain_adjust.sv
// Gain adjustment registers and result scaling for the sample converter
`timescale 1ns/1ps
`default_nettype none
module gain_adjust (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [gain_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [gain_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [gain_pkg::DATA_W-1:0] reg_rdata,
    input wire gain_pkg::sample_t raw_in,
    output gain_pkg::sample_t result_out,
    output logic [gain_pkg::GAIN_NUM_W-1:0] gain_setting
);
    import gain_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register request decode

    reg_req_t req;
    logic hit_high;
    logic hit_low;
    logic hit_extra;
    logic hit_any;

    assign req.wr = reg_wr;
    assign req.rd = reg_rd;
    assign req.addr = reg_addr;
    assign req.wdata = reg_wdata;

    assign hit_high = (req.addr == OFF_GAIN_HIGH);
    assign hit_low = (req.addr == OFF_GAIN_LOW);
    assign hit_extra = (req.addr == OFF_GAIN_EXTRA);
    assign hit_any = hit_high | hit_low | hit_extra;

    ////////////////////////////////////////////////////////////////////////////
    // Gain registers

    logic [HIGH_FIELD_W-1:0] gain_upper_field_q;
    logic [HIGH_FIELD_W-1:0] gain_upper_field_d;
    logic [LOW_FIELD_W-1:0] gain_lower_field_q;
    logic [LOW_FIELD_W-1:0] gain_lower_field_d;
    logic additional_gain_flag_q;
    logic additional_gain_flag_d;

    // Full byte, every bit writable
    assign gain_upper_field_d = (req.wr && hit_high) ? req.wdata : gain_upper_field_q;

    // Only bits 7..4 are stored; the reserved nibble is not kept
    assign gain_lower_field_d = (req.wr && hit_low) ?
        req.wdata[LOW_FIELD_LSB +: LOW_FIELD_W] : gain_lower_field_q;

    assign additional_gain_flag_d = (req.wr && hit_extra) ? req.wdata[EXTRA_BIT] : additional_gain_flag_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            gain_upper_field_q <= RST_GAIN_HIGH;
            gain_lower_field_q <= RST_GAIN_LOW[LOW_FIELD_LSB +: LOW_FIELD_W];
            additional_gain_flag_q <= RST_GAIN_EXTRA[EXTRA_BIT];
        end else begin
            gain_upper_field_q <= gain_upper_field_d;
            gain_lower_field_q <= gain_lower_field_d;
            additional_gain_flag_q <= additional_gain_flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [DATA_W-1:0] view_high;
    logic [DATA_W-1:0] view_low;
    logic [DATA_W-1:0] view_extra;
    logic [DATA_W-1:0] read_sel;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    assign view_high = gain_upper_field_q;
    // Reserved nibble reads as zero, so software sees what it should write
    assign view_low = {gain_lower_field_q, {LOW_FIELD_LSB{1'b0}}};
    assign view_extra = {{(DATA_W-1){1'b0}}, additional_gain_flag_q};

    assign read_sel = hit_high ? view_high :
                      hit_low ? view_low :
                      hit_extra ? view_extra : READ_ZERO;

    // Read data stand only in the cycle after the strobe
    assign rdata_d = req.rd ? read_sel : READ_ZERO;
    assign reg_rdata = rdata_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= READ_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Effective gain and result scaling

    logic [GAIN_NUM_W-1:0] gain_num;

    // Numerator over 4096: 0 up to 4159, i.e. 0 to about 1.015
    assign gain_num = gain_value(gain_upper_field_q, gain_lower_field_q, additional_gain_flag_q);
    assign gain_setting = gain_num;

    gain_mult u_mult (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .sample_in(raw_in),
        .gain(gain_num),
        .sample_out(result_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_write_high;
        reg_wr && (reg_addr == OFF_GAIN_HIGH);
    endsequence

    sequence s_read_high;
        reg_rd && (reg_addr == OFF_GAIN_HIGH);
    endsequence

    sequence s_write_low;
        reg_wr && (reg_addr == OFF_GAIN_LOW);
    endsequence

    sequence s_read_low;
        reg_rd && (reg_addr == OFF_GAIN_LOW);
    endsequence

    sequence s_read_extra;
        reg_rd && (reg_addr == OFF_GAIN_EXTRA);
    endsequence

    sequence s_write_extra;
        reg_wr && (reg_addr == OFF_GAIN_EXTRA);
    endsequence

    property p_high_readback;
        @(posedge clk_sys) disable iff (!rst_b)
        s_write_high ##1 s_read_high |=> (reg_rdata == $past(reg_wdata, 2));
    endproperty

    property p_low_readback;
        @(posedge clk_sys) disable iff (!rst_b)
        s_write_low ##1 s_read_low |=>
            (reg_rdata[DATA_W-1:LOW_FIELD_LSB] == $past(reg_wdata[DATA_W-1:LOW_FIELD_LSB], 2))
            && (reg_rdata[LOW_FIELD_LSB-1:0] == '0);
    endproperty

    AST_HIGH_READBACK: assert property (p_high_readback)
        else $error("gain upper byte read back differs from the value written");

    AST_LOW_READBACK: assert property (p_low_readback)
        else $error("gain lower nibble read back wrong or reserved bits not zero");

    AST_EXTRA_RESERVED: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_read_extra |=> (reg_rdata[DATA_W-1:1] == '0)
            && (reg_rdata[EXTRA_BIT] == $past(additional_gain_flag_q)))
        else $error("additional gain byte read back wrong");

    AST_UNMAPPED_ZERO: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        !(reg_rd && hit_any) |=> (reg_rdata == READ_ZERO))
        else $error("read data not zero for idle or unmapped access");

    AST_GAIN_RANGE: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (gain_setting <= GAIN_MAX)
        && (gain_setting == ({1'b0, gain_upper_field_q, gain_lower_field_q}
            + (GAIN_NUM_W'(additional_gain_flag_q) << EXTRA_SHIFT))))
        else $error("effective gain outside range or wrongly composed");

    AST_RESULT_SCALED: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        raw_in.valid |=> result_out.valid
            && (result_out.data == scale_sample($past(raw_in.data), $past(gain_num))))
        else $error("scaled result does not match raw sample times gain");

    AST_RESULT_ONLY_AFTER_RAW: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        !raw_in.valid |=> !result_out.valid && $stable(result_out.data))
        else $error("result changed without a raw sample");

    AST_UNITY_PASSTHROUGH: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        raw_in.valid && (gain_num == (GAIN_NUM_W'(1) << FRAC_BITS)) |=>
            (result_out.data == $past(raw_in.data)))
        else $error("unity gain did not pass the twelve-bit result through");

    AST_HIGH_WRITE: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_write_high |=> (gain_upper_field_q == $past(reg_wdata)))
        else $error("gain upper byte not updated by its write");

    AST_LOW_WRITE: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_write_low |=> (gain_lower_field_q == $past(reg_wdata[DATA_W-1:LOW_FIELD_LSB])))
        else $error("gain lower nibble not updated by its write");

    AST_EXTRA_WRITE: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_write_extra |=> (additional_gain_flag_q == $past(reg_wdata[EXTRA_BIT])))
        else $error("additional gain bit not updated by its write");

    AST_GAIN_HOLDS: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        !reg_wr |=> $stable(gain_setting))
        else $error("effective gain changed without a register write");

endmodule
`default_nettype wire

// ===== core/gain_mult.sv
// Registered scaling stage for conversion results
`timescale 1ns/1ps
`default_nettype none
module gain_mult (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire gain_pkg::sample_t sample_in,
    input wire logic [gain_pkg::GAIN_NUM_W-1:0] gain,
    output gain_pkg::sample_t sample_out
);
    import gain_pkg::*;

    sample_t out_q;
    sample_t out_d;

    assign out_d.valid = sample_in.valid;
    assign out_d.data = sample_in.valid ? scale_sample(sample_in.data, gain) : out_q.data;
    assign sample_out = out_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

endmodule
`default_nettype wire
